/* link_power_pkg.sv */
// Shared constants, encodings and carriers for the link, mode and power block.
package link_power_pkg;

  // ---------------------------------------------------------------------
  // Register offsets on the control port
  // ---------------------------------------------------------------------
  localparam logic [11:0] ADDR_POWER_TRIM_ONE = 12'h0037;
  localparam logic [11:0] ADDR_SOFT_CAL_TRIGGER = 12'h006c;
  localparam logic [11:0] ADDR_POWER_TRIM_TWO = 12'h029a;
  localparam logic [11:0] ADDR_POWER_TRIM_THREE = 12'h029b;
  localparam logic [11:0] ADDR_POWER_TRIM_FOUR = 12'h029c;
  localparam logic [11:0] ADDR_CAL_ENABLE = 12'h0061;
  localparam logic [11:0] ADDR_CAL_MODE = 12'h0062;
  localparam logic [11:0] ADDR_LOW_POWER_TRIGGER_CONTROL_CTRL = 12'h006b;
  localparam logic [11:0] ADDR_LINK_ENABLE = 12'h0200;
  localparam logic [11:0] ADDR_LINK_MODE = 12'h0201;
  localparam logic [11:0] ADDR_KM1 = 12'h0202;
  localparam logic [11:0] ADDR_ALARM_STATUS = 12'h02c0;

  // ---------------------------------------------------------------------
  // Reset values; the power trims default to high performance
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_POWER_TRIM_ONE = 8'h4b;
  localparam logic [7:0] RST_POWER_TRIM_TWO = 8'h0f;
  localparam logic [7:0] RST_POWER_TRIM_THREE = 8'h04;
  localparam logic [7:0] RST_POWER_TRIM_FOUR = 8'h1b;
  localparam logic [7:0] RST_KM1 = 8'h1f;
  localparam logic [7:0] GLITCH_HP_TRIM = 8'h04;

  // ---------------------------------------------------------------------
  // Calibration modes and timing counts in sample clocks
  // ---------------------------------------------------------------------
  localparam logic [1:0] CAL_MODE_FOREGROUND = 2'h0;
  localparam logic [1:0] CAL_MODE_BACKGROUND = 2'h1;
  localparam logic [1:0] CAL_MODE_LP_BACKGROUND = 2'h2;
  localparam int TRIG_DELAY_MIN_CYC = 500;
  localparam int TRIG_DELAY_MAX_CYC = 1000;
  localparam logic [11:0] TRIG_DELAY_CYC = 12'h02ee;
  localparam logic [11:0] SWAP_PERIOD_CYC = 12'h0fa0;
  localparam int LANES = 8;

  // Trigger sequencer states.
  typedef enum logic [1:0] {
    TRG_IDLE = 2'b01,
    TRG_WAIT = 2'b10
  } trig_state_e;

  // Link parameters derived from the mode selector.
  typedef struct packed {
    logic [3:0] lanes;
    logic [3:0] converters;
    logic [3:0] octets;
    logic [3:0] samples;
    logic [3:0] resolution;
    logic [5:0] bits_per_clk_x2;
    logic enc_64b66b;
    logic [8:0] frames_k;
    logic [1:0] mblk_e;
  } link_params_s;

  // Power trim settings handed to the analog core.
  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
    logic [7:0] four;
  } power_trim_s;

endpackage : link_power_pkg

/* link_mode_power.sv */
// Link configuration, FIFO lane alarms, power trims and calibration trigger.
// How it works
// - Pointer upset while link enabled sets only that lane's alarm.
// - Link enable low then high reinitializes FIFO.
// - Reset leaves high performance trim values.
// - Trim three trades power against glitch size.
// - Trigger gives core transition 500-1000 clocks later.
// - Foreground calibration never makes core transitions.
// - Mode selector derives lanes, converters, octets, samples, resolution and ratio.
// - Lane rate and PLL factor from ratio.
// - Frame count from register, 8b/10b only.
// - Extended multiblock count fixed one in 64b/66b.
// - Parameters go in alignment sequence, 8b/10b.
// - Disabled link held reset, powered down, gated.
// - Alarm bits hold until host writes one.
module link_mode_power
  import link_power_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic calibration_trigger_pin,
  input wire logic [LANES-1:0] lane_ptr_upset,
  output logic [LANES-1:0] lane_fifo_alarm,
  output logic fifo_reinit,
  output logic link_reset,
  output logic serdes_power_down,
  output logic link_clock_en,
  output logic ilas_enable,
  output logic [5:0] serdes_pll_mult_x2,
  output link_params_s link_params,
  output power_trim_s power_trim,
  output logic glitch_matches_hp,
  output logic core_transition
);

  // ---------------------------------------------------------------------
  // Mode decoding
  // ---------------------------------------------------------------------

  // Selectors beyond the table fall back to mode zero so the link never
  // starts with an undefined format.
  function automatic link_params_s derive_link(input logic [7:0] mode,
                                               input logic [7:0] km1);
    link_params_s p;
    p = '0;
    unique case (mode)
      8'h01: begin
        p.lanes = 4'h6; p.converters = 4'h4; p.octets = 4'h2;
        p.samples = 4'h2; p.resolution = 4'hc; p.bits_per_clk_x2 = 6'h14;
      end
      8'h02: begin
        p.lanes = 4'h4; p.converters = 4'h4; p.octets = 4'h1;
        p.samples = 4'h1; p.resolution = 4'h8; p.bits_per_clk_x2 = 6'h14;
      end
      8'h03: begin
        p.lanes = 4'h4; p.converters = 4'h4; p.octets = 4'h5;
        p.samples = 4'h4; p.resolution = 4'ha; p.bits_per_clk_x2 = 6'h19;
      end
      default: begin
        p.lanes = 4'h8; p.converters = 4'h8; p.octets = 4'h8;
        p.samples = 4'h5; p.resolution = 4'hc; p.bits_per_clk_x2 = 6'h10;
      end
    endcase
    p.enc_64b66b = 1'b0;
    // The frame count only matters to 8b/10b framing.
    if (p.enc_64b66b) begin
      p.frames_k = 9'h000;
      p.mblk_e = 2'h1;
    end else begin
      p.frames_k = {1'b0, km1} + 9'h001;
      p.mblk_e = 2'h0;
    end
    return p;
  endfunction : derive_link

  // Decodes a register write strobe at one address.
  function automatic logic hit(input logic [11:0] addr);
    return reg_wr && (reg_addr == addr);
  endfunction : hit

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  power_trim_s trim_q, trim_d;
  logic cal_enable_q, cal_enable_d;
  logic [1:0] cal_mode_q, cal_mode_d;
  logic low_power_trigger_control_ctrl_q, low_power_trigger_control_ctrl_d;
  logic link_enable_q, link_enable_d;
  logic [7:0] link_mode_q, link_mode_d;
  logic [7:0] km1_q, km1_d;
  logic [LANES-1:0] alarm_q, alarm_d;
  logic [7:0] rdata_q, rdata_d;
  logic soft_trig;

  // Writes store configuration; the alarm register clears on ones and a new
  // upset in the same cycle wins over the clear.
  always_comb begin
    trim_d = trim_q;
    cal_enable_d = cal_enable_q;
    cal_mode_d = cal_mode_q;
    low_power_trigger_control_ctrl_d = low_power_trigger_control_ctrl_q;
    link_enable_d = link_enable_q;
    link_mode_d = link_mode_q;
    km1_d = km1_q;
    if (hit(ADDR_POWER_TRIM_ONE)) trim_d.one = reg_wdata;
    if (hit(ADDR_POWER_TRIM_TWO)) trim_d.two = reg_wdata;
    if (hit(ADDR_POWER_TRIM_THREE)) trim_d.three = reg_wdata;
    if (hit(ADDR_POWER_TRIM_FOUR)) trim_d.four = reg_wdata;
    if (hit(ADDR_CAL_ENABLE)) cal_enable_d = reg_wdata[0];
    if (hit(ADDR_CAL_MODE)) cal_mode_d = reg_wdata[1:0];
    if (hit(ADDR_LOW_POWER_TRIGGER_CONTROL_CTRL)) low_power_trigger_control_ctrl_d = reg_wdata[0];
    if (hit(ADDR_LINK_ENABLE)) link_enable_d = reg_wdata[0];
    if (hit(ADDR_LINK_MODE)) link_mode_d = reg_wdata;
    if (hit(ADDR_KM1)) km1_d = reg_wdata;
    alarm_d = alarm_q;
    if (hit(ADDR_ALARM_STATUS)) alarm_d = alarm_q & ~reg_wdata;
    // Upsets are only meaningful while the FIFO is running.
    alarm_d = alarm_d | (lane_ptr_upset & {LANES{link_enable_q}});
    soft_trig = hit(ADDR_SOFT_CAL_TRIGGER);
  end

  // Read data is registered; unmapped addresses and the trigger read zero.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_POWER_TRIM_ONE: rdata_d = trim_q.one;
        ADDR_POWER_TRIM_TWO: rdata_d = trim_q.two;
        ADDR_POWER_TRIM_THREE: rdata_d = trim_q.three;
        ADDR_POWER_TRIM_FOUR: rdata_d = trim_q.four;
        ADDR_CAL_ENABLE: rdata_d = {7'h00, cal_enable_q};
        ADDR_CAL_MODE: rdata_d = {6'h00, cal_mode_q};
        ADDR_LOW_POWER_TRIGGER_CONTROL_CTRL: rdata_d = {7'h00, low_power_trigger_control_ctrl_q};
        ADDR_LINK_ENABLE: rdata_d = {7'h00, link_enable_q};
        ADDR_LINK_MODE: rdata_d = link_mode_q;
        ADDR_KM1: rdata_d = km1_q;
        ADDR_ALARM_STATUS: rdata_d = alarm_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Registers wake in high performance mode with the link disabled.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_q <= {RST_POWER_TRIM_ONE, RST_POWER_TRIM_TWO,
                 RST_POWER_TRIM_THREE, RST_POWER_TRIM_FOUR};
      cal_enable_q <= 1'b0;
      cal_mode_q <= CAL_MODE_FOREGROUND;
      low_power_trigger_control_ctrl_q <= 1'b0;
      link_enable_q <= 1'b0;
      link_mode_q <= 8'h00;
      km1_q <= RST_KM1;
      alarm_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      trim_q <= trim_d;
      cal_enable_q <= cal_enable_d;
      cal_mode_q <= cal_mode_d;
      low_power_trigger_control_ctrl_q <= low_power_trigger_control_ctrl_d;
      link_enable_q <= link_enable_d;
      link_mode_q <= link_mode_d;
      km1_q <= km1_d;
      alarm_q <= alarm_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // Link control and derived parameters
  // ---------------------------------------------------------------------
  link_params_s params_q, params_d;
  logic en_dly_q, en_dly_d;
  logic reinit_q, reinit_d;

  // A fresh enable edge restarts the FIFO pointers; parameters are
  // re-derived every cycle, which is why the host must disable first.
  always_comb begin
    params_d = derive_link(link_mode_q, km1_q);
    en_dly_d = link_enable_q;
    reinit_d = link_enable_q && !en_dly_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      params_q <= '0;
      en_dly_q <= 1'b0;
      reinit_q <= 1'b0;
    end else begin
      params_q <= params_d;
      en_dly_q <= en_dly_d;
      reinit_q <= reinit_d;
    end
  end

  // While disabled the link logic sits in reset, unpowered and unclocked.
  assign link_reset = !link_enable_q;
  assign serdes_power_down = !link_enable_q;
  assign link_clock_en = link_enable_q;
  assign fifo_reinit = reinit_q;
  assign ilas_enable = link_enable_q && !params_q.enc_64b66b;
  assign serdes_pll_mult_x2 = params_q.bits_per_clk_x2;
  assign link_params = params_q;
  assign lane_fifo_alarm = alarm_q;
  assign power_trim = trim_q;
  assign reg_rdata = rdata_q;
  assign glitch_matches_hp = (trim_q.three >= GLITCH_HP_TRIM);

  // ---------------------------------------------------------------------
  // Calibration trigger and core transition timing
  // ---------------------------------------------------------------------
  logic [2:0] pin_sync_q, pin_sync_d;
  logic pin_level_q, pin_level_d;
  trig_state_e trg_state_q, trg_state_d;
  logic [11:0] trg_cnt_q, trg_cnt_d;
  logic swap_q, swap_d;
  logic bg_active, trig_mode, trig_event;

  // The pin passes three flops and counts as changed once the last two
  // agree, so a single metastable sample cannot fire a trigger.
  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], calibration_trigger_pin};
    pin_level_d = pin_level_q;
    if (pin_sync_q[1] == pin_sync_q[2]) pin_level_d = pin_sync_q[2];
    bg_active = cal_enable_q && (cal_mode_q != CAL_MODE_FOREGROUND);
    trig_mode = cal_enable_q && low_power_trigger_control_ctrl_q &&
                (cal_mode_q == CAL_MODE_LP_BACKGROUND);
    trig_event = soft_trig || (pin_level_d && !pin_level_q);
    trg_state_d = trg_state_q;
    trg_cnt_d = trg_cnt_q;
    swap_d = 1'b0;
    unique case (trg_state_q)
      TRG_IDLE: begin
        if (trig_mode) begin
          trg_cnt_d = 12'h000;
          // Triggers arriving during a wait are dropped, not queued.
          if (trig_event) trg_state_d = TRG_WAIT;
        end else if (bg_active) begin
          // Free running swaps when the host does not time them.
          trg_cnt_d = trg_cnt_q + 12'h001;
          if (trg_cnt_q == SWAP_PERIOD_CYC - 12'h001) begin
            trg_cnt_d = 12'h000;
            swap_d = 1'b1;
          end
        end else begin
          trg_cnt_d = 12'h000;
        end
      end
      TRG_WAIT: begin
        trg_cnt_d = trg_cnt_q + 12'h001;
        if (!bg_active) begin
          trg_state_d = TRG_IDLE;
          trg_cnt_d = 12'h000;
        end else if (trg_cnt_q == TRIG_DELAY_CYC - 12'h001) begin
          swap_d = 1'b1;
          trg_state_d = TRG_IDLE;
          trg_cnt_d = 12'h000;
        end
      end
      default: begin
        trg_state_d = TRG_IDLE;
        trg_cnt_d = 12'h000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_q <= 3'h0;
      pin_level_q <= 1'b0;
      trg_state_q <= TRG_IDLE;
      trg_cnt_q <= 12'h000;
      swap_q <= 1'b0;
    end else begin
      pin_sync_q <= pin_sync_d;
      pin_level_q <= pin_level_d;
      trg_state_q <= trg_state_d;
      trg_cnt_q <= trg_cnt_d;
      swap_q <= swap_d;
    end
  end

  assign core_transition = swap_q;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  logic [11:0] since_trig_q, since_trig_d;

  // Helper count of clocks since an accepted trigger, saturating, so the
  // long quiet stretch is checked without unrolling a huge repetition.
  always_comb begin
    since_trig_d = since_trig_q;
    if (since_trig_q != 12'hfff) since_trig_d = since_trig_q + 12'h001;
    if (trg_state_q == TRG_IDLE && trig_mode && trig_event) begin
      since_trig_d = 12'h000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_trig_q <= 12'hfff;
    end else begin
      since_trig_q <= since_trig_d;
    end
  end

  chk_trigger_not_early: assert property (@(posedge clk) disable iff (!reset_n)
    (core_transition && $past(trg_state_q) == TRG_WAIT) |->
    (since_trig_q >= 12'h01f4 && since_trig_q <= 12'h03e8))
    else $error("Core transition before 500 or after 1000 clocks.");

  chk_alarm_set_lane: assert property (@(posedge clk) disable iff (!reset_n)
    link_enable_q |=> ((alarm_q & $past(lane_ptr_upset)) ==
                       $past(lane_ptr_upset)))
    else $error("Lane upset did not set its alarm bit.");

  chk_alarm_sticky_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !hit(ADDR_ALARM_STATUS) |=> ((alarm_q & $past(alarm_q)) == $past(alarm_q)))
    else $error("Alarm bit dropped without a clearing write.");

  chk_fifo_reinit_edge: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(link_enable_q) |=> fifo_reinit ##1 !fifo_reinit)
    else $error("FIFO reinit missing after link re-enable.");

  chk_disabled_link_off: assert property (@(posedge clk) disable iff (!reset_n)
    !link_enable_q |-> (link_reset && serdes_power_down && !link_clock_en))
    else $error("Disabled link not held in reset and powered down.");

  chk_trigger_delay_window: assert property (@(posedge clk) disable iff (!reset_n)
    (trg_state_q == TRG_IDLE && trig_mode && trig_event) ##1
    (bg_active && trig_mode) [*8] |->
    ##[492:992] core_transition)
    else $error("Core transition outside the 500 to 1000 clock window.");

  chk_foreground_no_swap: assert property (@(posedge clk) disable iff (!reset_n)
    (!cal_enable_q || cal_mode_q == CAL_MODE_FOREGROUND) [*2] |->
    !core_transition)
    else $error("Core transition while in foreground calibration.");

  chk_frames_from_km1: assert property (@(posedge clk) disable iff (!reset_n)
    $stable(km1_q) && !params_q.enc_64b66b |=>
    params_q.frames_k == {1'b0, $past(km1_q)} + 9'h001)
    else $error("Frame count does not follow the minus-one register.");

  chk_mblk_e_fixed: assert property (@(posedge clk) disable iff (!reset_n)
    params_q.enc_64b66b |-> (params_q.mblk_e == 2'h1))
    else $error("Extended multiblock count is not one in 64b/66b mode.");

  chk_pll_follows_ratio: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(link_mode_q) |-> ##2 (serdes_pll_mult_x2 ==
                                   link_params.bits_per_clk_x2))
    else $error("Serializer PLL factor differs from the lane ratio.");

  chk_ilas_8b10b_only: assert property (@(posedge clk) disable iff (!reset_n)
    ilas_enable |-> (!params_q.enc_64b66b && link_enable_q))
    else $error("Alignment sequence enabled outside 8b/10b mode.");

  chk_glitch_trim_flag: assert property (@(posedge clk) disable iff (!reset_n)
    hit(ADDR_POWER_TRIM_THREE) |=>
    (glitch_matches_hp == ($past(reg_wdata) >= GLITCH_HP_TRIM)))
    else $error("Glitch flag does not follow trim three.");

endmodule : link_mode_power

/* link_host_model.sv */
// Host controller model driving the register strobe port.
module link_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Released lines show the inverse of the last value, never a stale copy.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0fff;
    reg_wdata = 8'h00;
  end

  // One write: strobe held across exactly one rising edge.
  task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : write_reg

  // One read; data is registered at the taking edge.
  task automatic read_reg(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : read_reg

  // Power mode change, made only with calibration and link off.
  task automatic power_mode(input bit low);
    write_reg(12'h0061, 8'h00);
    write_reg(12'h0200, 8'h00);
    write_reg(12'h0037, low ? 8'h46 : 8'h4b);
    write_reg(12'h029a, low ? 8'h06 : 8'h0f);
    write_reg(12'h029b, low ? 8'h00 : 8'h04);
    write_reg(12'h029c, low ? 8'h14 : 8'h1b);
  endtask : power_mode

  // Toggle the link enable, then clear stale lane alarms.
  task automatic relink();
    write_reg(12'h0200, 8'h00);
    write_reg(12'h0200, 8'h01);
    write_reg(12'h02c0, 8'hff);
  endtask : relink
endmodule : link_host_model

/* link_mode_power_bench.sv */
// Self-checking bench for the link, mode and power block.
module link_mode_power_bench;
  import link_power_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, reset_n, reg_wr, reg_rd, pin, fifo_reinit, link_reset;
  logic serdes_power_down, link_clock_en, ilas_enable, glitch, core_tr;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [LANES-1:0] upset, alarm;
  logic [5:0] pll_x2;
  link_params_s lp;
  power_trim_s trim;
  int n_errors, comparisons, cycles, n_reinit, n, seed, km1, lane;
  int regm[int];
  int alarm_m;
  int tab[4][6] = '{'{8, 8, 8, 5, 12, 16}, '{6, 4, 2, 2, 12, 20},
                    '{4, 4, 1, 1, 8, 20}, '{4, 4, 5, 4, 10, 25}};

  link_mode_power DUT (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .calibration_trigger_pin(pin),
    .lane_ptr_upset(upset), .lane_fifo_alarm(alarm),
    .fifo_reinit(fifo_reinit), .link_reset(link_reset),
    .serdes_power_down(serdes_power_down), .link_clock_en(link_clock_en),
    .ilas_enable(ilas_enable), .serdes_pll_mult_x2(pll_x2),
    .link_params(lp), .power_trim(trim), .glitch_matches_hp(glitch),
    .core_transition(core_tr));

  link_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ---------------------------------------------------------------
  // Clock, timeout and monitors
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The ceiling is about three and a half times the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  // Reinit pulse cycles counted at the settled falling edge.
  always @(negedge clk) if (fifo_reinit === 1'b1) n_reinit++;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  // Write through the host and mirror the effect in the model.
  task automatic wr(input int a, input int d);
    host.write_reg(a[11:0], d[7:0]);
    if (regm.exists(a)) regm[a] = d;
    if (a == 'h2c0) alarm_m &= ~d;
  endtask : wr

  // Read and compare with the model; unmapped places read zero.
  task automatic rd_chk(input int a);
    host.read_reg(a[11:0], rv);
    if (a == 'h2c0) check(rv, alarm_m, "alarm read");
    else check(rv, regm.exists(a) ? regm[a] : 0, "read");
  endtask : rd_chk

  // Counts cycles until the core transition pulse, bounded.
  task automatic wait_core(output int k);
    k = 0;
    while (core_tr !== 1'b1 && k < 1200) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_core

  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h8d12;
    reset_n = 1'b0;
    pin = 1'b0;
    upset = '0;
    regm = '{'h037: 'h4b, 'h29a: 'h0f, 'h29b: 'h04, 'h29c: 'h1b, 'h202: 'h1f};
    alarm_m = 0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    // Reset state: high performance trims, link held off.
    check(trim, 32'h4b0f_041b, "reset trims");
    check({link_reset, serdes_power_down, link_clock_en}, 3'b110, "off");
    check(glitch, 1'b1, "glitch at reset");
    foreach (regm[a]) rd_chk(a);
    rd_chk('h123);
    rd_chk('h06c);
    // Upsets are ignored while the link is disabled.
    @(negedge clk) upset = 8'hff;
    @(negedge clk) upset = '0;
    @(negedge clk) check(alarm, 8'h00, "disabled upset");
    $display("test reset done");
    // Low power set, random trim three values, back to high performance.
    host.power_mode(1'b1);
    check(trim, 32'h4606_0014, "low power");
    check(glitch, 1'b0, "lp glitch");
    repeat (4) begin
      n = $unsigned($random(seed)) % 8;
      wr('h29b, n);
      check(glitch, n >= 4, "trim three");
    end
    host.power_mode(1'b0);
    check(trim, 32'h4b0f_041b, "high perf");
    $display("test power done");
    // Every mode with a random valid frame count.
    for (int m = 0; m < 4; m++) begin
      km1 = ($unsigned($random(seed)) % 8 + 1) * 32 - 1;
      wr('h201, m);
      wr('h202, km1);
      repeat (2) @(negedge clk);
      check(pll_x2, tab[m][5], "pll factor");
      check({lp.lanes, lp.converters, lp.octets, lp.samples, lp.resolution},
            {tab[m][0][3:0], tab[m][1][3:0], tab[m][2][3:0], tab[m][3][3:0],
             tab[m][4][3:0]}, "mode fields");
      check(lp.frames_k, km1 + 1, "frames");
      check(lp.enc_64b66b, 1'b0, "encoding");
      n = n_reinit;
      host.relink();
      alarm_m = 0;
      check(n_reinit - n, 1, "reinit pulse");
      check({ilas_enable, link_reset, serdes_power_down, link_clock_en},
            4'b1001, "enabled");
      wr('h200, 0);
      check({ilas_enable, link_reset, link_clock_en}, 3'b010, "dis");
    end
    $display("test modes done");
    // One lane upset: only that bit, sticky until written with one.
    host.relink();
    lane = $unsigned($random(seed)) % 8;
    @(negedge clk) upset = 8'h01 << lane;
    @(negedge clk) upset = '0;
    alarm_m = 1 << lane;
    repeat (5) @(negedge clk);
    check(alarm, alarm_m, "one lane");
    wr('h2c0, ~alarm_m & 'hff);
    rd_chk('h2c0);
    wr('h2c0, alarm_m);
    check(alarm, 8'h00, "cleared");
    $display("test alarm done");
    // Triggered core transitions, soft and pin, then foreground.
    wr('h061, 1);
    wr('h062, 2);
    wr('h06b, 1);
    wr('h06c, 1);
    wait_core(n);
    check(n >= 500 && n <= 1000, 1'b1, "soft delay");
    @(negedge clk) pin = 1'b1;
    wait_core(n);
    check(n >= 500 && n <= 1000, 1'b1, "pin delay");
    pin = 1'b0;
    wr('h062, 0);
    wr('h06c, 1);
    n = 0;
    repeat (4100) @(negedge clk) if (core_tr === 1'b1) n++;
    check(n, 0, "foreground");
    $display("test trigger done");
    stop_test();
  end
endmodule : link_mode_power_bench
